// ===== hw/macrocell_cfg_pkg.sv
// Constants for the macrocell architecture configuration block.
// Assumes a 100 MHz clock and an AHB-Lite slave with 32-bit data.
package macrocell_cfg_pkg;
	// =========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] MODE_OFFSET = 8'h00;
	localparam logic [7:0] CELLSEL_OFFSET = 8'h04;
	localparam logic [7:0] POLARITY_OFFSET = 8'h08;
	localparam logic [7:0] COMMAND_OFFSET = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET = 8'h10;
	localparam logic [7:0] ARRAYADDR_OFFSET = 8'h14;
	localparam logic [7:0] ARRAYDATA_OFFSET = 8'h18;
	localparam logic [7:0] CYCLES_OFFSET = 8'h1C;
	localparam logic [7:0] MACROCELL_OFFSET = 8'h20;
	// =========================================
	// Field layout
	localparam int NUM_CELLS = 8;
	localparam int ARRAY_WORDS = 64;
	localparam int ARRAY_ADDR_W = 6;
	localparam int CMD_PROGRAM_BIT = 0;
	localparam int CMD_SECURE_BIT = 1;
	localparam int CMD_ERASE_BIT = 2;
	localparam int STAT_SECURE_BIT = 0;
	localparam int STAT_REJECT_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int CYCLE_W = 16;
	// =========================================
	// Reset values
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] CELLSEL_RESET = 8'h00;
	localparam logic [7:0] POLARITY_RESET = 8'h00;
	localparam logic [31:0] ERASED_WORD = 32'h00000000;
	// =========================================
	// Architecture modes
	typedef enum logic [1:0] {
		simple_combinatorial_mode = 2'b00,
		registered_mode = 2'b01,
		combinatorial_io_mode = 2'b11
	} arch_mode_type;
	// Per-macrocell function
	typedef enum logic [2:0] {
		FN_INPUT = 3'h0,
		FN_OUTPUT = 3'h1,
		FN_REGISTER = 3'h2,
		FN_IO = 3'h3,
		FN_TRISTATE = 3'h4
	} cell_fn_type;
	// Erase engine states, Gray along idle-clear-done
	typedef enum logic [1:0] {
		ER_IDLE = 2'b00,
		ER_CLEAR = 2'b01,
		ER_DONE = 2'b11
	} erase_state_type;
endpackage : macrocell_cfg_pkg

// ===== hw/output_logic_macrocell.sv
// One output logic macrocell: polarity, D register, output select.
// Assumes configuration bits are static during normal operation.
module output_logic_macrocell
	import macrocell_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sumTerm,
	input wire logic ptEnable,
	input wire logic groupEnable,
	input wire logic [2:0] cellFn,
	input wire logic invertPol,
	output logic pinOut,
	output logic pinOe,
	output logic feedback
);
	logic regQ_ff;
	wire logic polData = sumTerm ^ invertPol;
	wire logic isReg = (cellFn == FN_REGISTER);
	// =========================================
	// Register captures post-polarity function
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regQ_ff <= 1'b0;
		end else if (isReg) begin
			regQ_ff <= polData;
		end
	end
	// Registered pins drive the inverted value
	assign pinOut = isReg ? ~regQ_ff : polData;
	assign pinOe = (cellFn == FN_OUTPUT) ? 1'b1 :
		isReg ? groupEnable :
		((cellFn == FN_IO) || (cellFn == FN_TRISTATE)) ? ptEnable : 1'b0;
	assign feedback = isReg ? regQ_ff : 1'b0;
endmodule : output_logic_macrocell

// ===== hw/macrocell_mode_config.sv
// Architecture configuration of an eight-macrocell sum-of-products device.
// Assumes an AHB-Lite master, single word transfers, one 100 MHz clock.
module macrocell_mode_config
	import macrocell_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] sumTerm,
	input wire logic [7:0] ptEnable,
	input wire logic regOutEnableN,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	output logic [7:0] feedback,
	output logic [1:0] dedicatedRole
);
	// =========================================
	// Configuration state
	logic [1:0] mode_ff;
	logic [7:0] cellSel_ff;
	logic [7:0] polarity_ff;
	logic secure_ff;
	logic reject_ff;
	logic [ARRAY_ADDR_W-1:0] arrAddr_ff;
	logic [31:0] arrayMem_ff [ARRAY_WORDS];
	logic [CYCLE_W-1:0] cycles_ff;
	erase_state_type erState_ff;
	logic [ARRAY_ADDR_W-1:0] erIdx_ff;
	logic oeSync1_ff;
	logic oeSync2_ff;
	logic [31:0] rdata_ff;
	// Address phase capture
	logic wrPend_ff;
	logic [7:0] wrAddr_ff;
	// =========================================
	// Bus decode
	wire logic accept = hsel && hready && htrans[1];
	wire logic doRead = accept && !hwrite;
	wire logic [7:0] rdAddr = haddr[7:0];
	wire logic busy = (erState_ff != ER_IDLE);
	wire logic wrMode = wrPend_ff && (wrAddr_ff == MODE_OFFSET);
	wire logic wrCell = wrPend_ff && (wrAddr_ff == CELLSEL_OFFSET);
	wire logic wrPol = wrPend_ff && (wrAddr_ff == POLARITY_OFFSET);
	wire logic wrCmd = wrPend_ff && (wrAddr_ff == COMMAND_OFFSET);
	wire logic wrAddrReg = wrPend_ff && (wrAddr_ff == ARRAYADDR_OFFSET);
	wire logic wrData = wrPend_ff && (wrAddr_ff == ARRAYDATA_OFFSET);
	// Configuration writes, except to ARRAYADDR, only while unlocked and idle
	wire logic cfgOpen = !secure_ff && !busy;
	wire logic progEvent = wrCmd && hwdata[CMD_PROGRAM_BIT] && cfgOpen;
	wire logic secureEvent = wrCmd && hwdata[CMD_SECURE_BIT] && !busy;
	wire logic eraseEvent = wrCmd && hwdata[CMD_ERASE_BIT] && !busy;
	wire logic blocked = (wrMode || wrCell || wrPol || wrData ||
		(wrCmd && hwdata[CMD_PROGRAM_BIT])) && !cfgOpen;
	wire logic rdArrayBlocked = doRead && (rdAddr == ARRAYDATA_OFFSET) && secure_ff;
	wire logic [7:0] modeWord = {6'h00, mode_ff};
	// Read mux
	logic [31:0] rdMux;
	always_comb begin
		case (rdAddr)
			MODE_OFFSET: rdMux = {24'h000000, modeWord};
			CELLSEL_OFFSET: rdMux = {24'h000000, cellSel_ff};
			POLARITY_OFFSET: rdMux = {24'h000000, polarity_ff};
			STATUS_OFFSET: rdMux = {29'h00000000, busy, reject_ff, secure_ff};
			ARRAYADDR_OFFSET: rdMux = {26'h0000000, arrAddr_ff};
			ARRAYDATA_OFFSET: rdMux = secure_ff ? ERASED_WORD : arrayMem_ff[arrAddr_ff];
			CYCLES_OFFSET: rdMux = {16'h0000, cycles_ff};
			MACROCELL_OFFSET: rdMux = {24'h000000, feedback};
			default: rdMux = 32'h00000000;
		endcase
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;
	// =========================================
	// Bus phase registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
		end else begin
			wrPend_ff <= accept && hwrite;
			wrAddr_ff <= haddr[7:0];
			rdata_ff <= doRead ? rdMux : rdata_ff;
		end
	end
	// =========================================
	// Static configuration, changed by register writes and, except arrAddr_ff, cleared by bulk erase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= MODE_RESET;
			cellSel_ff <= CELLSEL_RESET;
			polarity_ff <= POLARITY_RESET;
			arrAddr_ff <= '0;
		end else if (erState_ff == ER_CLEAR) begin
			mode_ff <= MODE_RESET;
			cellSel_ff <= CELLSEL_RESET;
			polarity_ff <= POLARITY_RESET;
		end else begin
			if (wrMode && cfgOpen && (hwdata[1:0] != 2'b10)) begin
				mode_ff <= hwdata[1:0];
			end
			if (wrCell && cfgOpen) begin
				cellSel_ff <= hwdata[7:0];
			end
			if (wrPol && cfgOpen) begin
				polarity_ff <= hwdata[7:0];
			end
			if (wrAddrReg) begin
				arrAddr_ff <= hwdata[ARRAY_ADDR_W-1:0];
			end
		end
	end
	// =========================================
	// Array storage, cleared word by word on bulk erase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < ARRAY_WORDS; i++) begin
				arrayMem_ff[i] <= ERASED_WORD;
			end
		end else if (erState_ff == ER_CLEAR) begin
			arrayMem_ff[erIdx_ff] <= ERASED_WORD;
		end else if (wrData && cfgOpen) begin
			arrayMem_ff[arrAddr_ff] <= hwdata;
		end
	end
	// =========================================
	// Security cell, reject flag, cycle counter, erase engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secure_ff <= 1'b0;
			reject_ff <= 1'b0;
			cycles_ff <= '0;
			erState_ff <= ER_IDLE;
			erIdx_ff <= '0;
		end else begin
			// Set wins over clear
			if (blocked || rdArrayBlocked) begin
				reject_ff <= 1'b1;
			end else if (wrCmd && !hwdata[CMD_PROGRAM_BIT]) begin
				reject_ff <= 1'b0;
			end
			if (progEvent) begin
				cycles_ff <= cycles_ff + 1'b1;
			end
			case (erState_ff)
				ER_IDLE: begin
					if (eraseEvent) begin
						erState_ff <= ER_CLEAR;
						erIdx_ff <= '0;
					end else if (secureEvent) begin
						secure_ff <= 1'b1;
					end
				end
				ER_CLEAR: begin
					erIdx_ff <= erIdx_ff + 1'b1;
					if (erIdx_ff == ARRAY_ADDR_W'(ARRAY_WORDS - 1)) begin
						erState_ff <= ER_DONE;
					end
				end
				ER_DONE: begin
					secure_ff <= 1'b0;
					erState_ff <= ER_IDLE;
				end
				default: erState_ff <= ER_IDLE;
			endcase
		end
	end
	// =========================================
	// Output enable pin passes two flip-flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oeSync1_ff <= 1'b1;
			oeSync2_ff <= 1'b1;
		end else begin
			oeSync1_ff <= regOutEnableN;
			oeSync2_ff <= oeSync1_ff;
		end
	end
	wire logic isRegMode = (mode_ff == registered_mode);
	wire logic groupEnable = isRegMode && !oeSync2_ff;
	// Dedicated pins: bit0 clock role, bit1 enable role
	assign dedicatedRole = {isRegMode, isRegMode};
	// =========================================
	// Per-cell function decode and macrocells
	genvar g;
	generate
		for (g = 0; g < NUM_CELLS; g++) begin : cells
			logic [2:0] fn;
			wire logic outer = (g == 0) || (g == NUM_CELLS - 1);
			always_comb begin
				case (mode_ff)
					simple_combinatorial_mode:
						fn = cellSel_ff[g] ? FN_OUTPUT : FN_INPUT;
					registered_mode:
						fn = cellSel_ff[g] ? FN_REGISTER : FN_IO;
					combinatorial_io_mode:
						fn = outer ? FN_TRISTATE : FN_IO;
					default: fn = FN_INPUT;
				endcase
			end
			output_logic_macrocell cellInst (
				.clk(clk),
				.rst(rst),
				.sumTerm(sumTerm[g]),
				.ptEnable(ptEnable[g]),
				.groupEnable(groupEnable),
				.cellFn(fn),
				.invertPol(polarity_ff[g]),
				.pinOut(pinOut[g]),
				.pinOe(pinOe[g]),
				.feedback(feedback[g])
			);
		end
	endgenerate
endmodule : macrocell_mode_config

// ===== tb/macrocell_mode_config_chk.sv
// Port checker for the macrocell configuration block.
// Assumes bind onto macrocell_mode_config, single clock, async reset.
module macrocell_mode_config_chk
	import macrocell_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic regOutEnableN,
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] feedback,
	input wire logic [1:0] dedicatedRole
);
	timeunit 1ns;
	timeprecision 1ns;
	// =========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire wrTake = hsel && hready && htrans[1] && hwrite;
	sequence cycRead;
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == CYCLES_OFFSET;
	endsequence
	sequence enOff;
		regOutEnableN [*3];
	endsequence
	a_zero_wait: assert property (hreadyout && !hresp) else $error("bus wait or error");
	a_role_legal: assert property (dedicatedRole == 2'h3 || dedicatedRole == 2'h0)
		else $error("dedicated pin roles split");
	a_fb_only_reg: assert property (dedicatedRole == 2'h0 |-> feedback == 8'h00)
		else $error("register content outside registered mode");
	a_reg_pin_inv: assert property ((feedback & pinOut) == 8'h00)
		else $error("registered pin not inverted");
	a_reset_quiet: assert property ($fell(rst) |-> pinOe == 8'h00 && feedback == 8'h00)
		else $error("pins or registers active after reset");
	a_role_change: assert property ($changed(dedicatedRole) && dedicatedRole == 2'h3 |->
		$past(wrTake, 2)) else $error("mode changed without a write");
	a_oe_disable: assert property (enOff |-> (feedback & pinOe) == 8'h00)
		else $error("registered output driven while disabled");
	a_cycles_read: assert property (cycRead |=> hrdata[31:16] == 16'h0000)
		else $error("cycle count wider than field");
endmodule : macrocell_mode_config_chk

// ===== tb/emul_map_model.sv
// Programmer model: emulated register count to cell selection.
// Assumes counts of 8, 6 or 4; others select no cell.
module emul_map_model (
	input wire logic [3:0] regCount,
	output logic [7:0] cellSel
);
	timeunit 1ns;
	timeprecision 1ns;
	// Centre cells stay registered, outer pairs drop out
	assign cellSel = (regCount == 4'h8) ? 8'hFF :
		(regCount == 4'h6) ? 8'h7E : (regCount == 4'h4) ? 8'h3C : 8'h00;
endmodule : emul_map_model

// ===== tb/macrocell_mode_config_tb.sv
// Self-checking bench for the macrocell configuration block.
// Assumes a zero-wait AHB-Lite slave and the programmer map model.
module macrocell_mode_config_tb
	import macrocell_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] sumTerm = 8'h00;
	logic [7:0] ptEnable = 8'h00;
	logic regOutEnableN = 1'b0;
	logic [3:0] regCnt = 4'h8;
	logic dataRd = 1'b0;
	logic [31:0] expQ[$];
	logic [7:0] rnd = 8'h3A;
	logic [7:0] pol;
	logic [7:0] offs [7] = '{MODE_OFFSET, CELLSEL_OFFSET, POLARITY_OFFSET, STATUS_OFFSET,
		CYCLES_OFFSET, MACROCELL_OFFSET, 8'h40};
	int err_total = 0;
	int compares = 0;
	wire hready;
	wire [31:0] hrdata;
	wire hreadyout;
	wire hresp;
	wire [7:0] pinOut;
	wire [7:0] pinOe;
	wire [7:0] feedback;
	wire [7:0] emuSel;
	wire [1:0] dedicatedRole;
	assign hready = hreadyout;
	always #5 clk = ~clk;
	macrocell_mode_config DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sumTerm(sumTerm),
		.ptEnable(ptEnable), .regOutEnableN(regOutEnableN), .pinOut(pinOut), .pinOe(pinOe),
		.feedback(feedback), .dedicatedRole(dedicatedRole));
	emul_map_model MAP (.regCount(regCnt), .cellSel(emuSel));
	// =========================================
	// Helpers
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task test_done;
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	task chkRd(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t read %h exp %h", $time, got, exp);
		end
	endtask : chkRd
	task chkPin(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t pins %h exp %h", $time, got, exp);
		end
	endtask : chkPin
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	// Read data monitor, oldest note first
	always @(posedge clk) begin
		if (dataRd) chkRd(hrdata, expQ.pop_front());
		dataRd <= hsel && htrans[1] && hready && !hwrite;
	end
	// Watchdog
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	// =========================================
	// Scenarios
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[i]) rd(offs[i], 32'h0);
		@(negedge clk) chkPin(pinOe, 8'h00);
		pol = lfsr(rnd);
		rnd = lfsr(pol);
		wr(POLARITY_OFFSET, {24'h0, pol});
		wr(CELLSEL_OFFSET, 32'hFF);
		sumTerm <= rnd;
		ptEnable <= ~rnd;
		@(negedge clk) chkPin(pinOut, rnd ^ pol);
		chkPin(pinOe, 8'hFF);
		chkPin({6'h00, dedicatedRole}, 8'h00);
		wr(MODE_OFFSET, 32'h3);
		@(negedge clk) chkPin({6'h00, pinOe[7], pinOe[0]}, {6'h00, ~rnd[7], ~rnd[0]});
		chkPin({6'h00, dedicatedRole}, 8'h00);
		wr(MODE_OFFSET, 32'h2);
		rd(MODE_OFFSET, 32'h3);
		wr(MODE_OFFSET, 32'h1);
		@(negedge clk) chkPin({6'h00, dedicatedRole}, 8'h03);
		for (int i = 0; i < 3; i++) begin
			regCnt <= 4'(8 - 2 * i);
			@(posedge clk);
			wr(CELLSEL_OFFSET, {24'h0, emuSel});
			pol = lfsr(rnd);
			rnd = lfsr(pol);
			wr(POLARITY_OFFSET, {24'h0, pol});
			sumTerm <= pol;
			repeat (2) @(posedge clk);
			@(negedge clk) chkPin(pinOut & emuSel, emuSel);
			sumTerm <= rnd;
			repeat (2) @(posedge clk);
			@(negedge clk) chkPin(feedback, (rnd ^ pol) & emuSel);
			chkPin(pinOe & emuSel, emuSel);
		end
		// Enable pin changes on a rising edge like the bus inputs
		@(posedge clk);
		regOutEnableN <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) chkPin(pinOe & emuSel, 8'h00);
		wr(ARRAYADDR_OFFSET, 32'h5);
		wr(ARRAYDATA_OFFSET, 32'hA5C30F96);
		wr(COMMAND_OFFSET, 32'h1);
		rd(ARRAYADDR_OFFSET, 32'h5);
		rd(CYCLES_OFFSET, 32'h1);
		rd(ARRAYDATA_OFFSET, 32'hA5C30F96);
		wr(COMMAND_OFFSET, 32'h2);
		rd(STATUS_OFFSET, 32'h1);
		wr(ARRAYDATA_OFFSET, 32'h1);
		wr(MODE_OFFSET, 32'h0);
		wr(COMMAND_OFFSET, 32'h1);
		rd(STATUS_OFFSET, 32'h3);
		rd(ARRAYDATA_OFFSET, 32'h0);
		rd(MODE_OFFSET, 32'h1);
		rd(CYCLES_OFFSET, 32'h1);
		wr(COMMAND_OFFSET, 32'h4);
		rd(STATUS_OFFSET, 32'h5);
		repeat (70) @(posedge clk);
		rd(STATUS_OFFSET, 32'h0);
		rd(MODE_OFFSET, 32'h0);
		rd(ARRAYDATA_OFFSET, 32'h0);
		rd(CYCLES_OFFSET, 32'h1);
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule : macrocell_mode_config_tb
bind macrocell_mode_config macrocell_mode_config_chk chk (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .regOutEnableN(regOutEnableN), .pinOut(pinOut),
	.pinOe(pinOe), .feedback(feedback), .dedicatedRole(dedicatedRole));
